// ### design/fom_pkg.sv
// Purpose: Shared constants and types for the fault output and margin select block.
// Assumes: Register index is byte address / 4 on APB.
// Notes:   Configuration bytes reset to zero until loaded by software.
package fom_pkg;

    // Register indices
    localparam logic [6:0] IDX_F1_LO  = 7'h15;
    localparam logic [6:0] IDX_F1_HI  = 7'h16;
    localparam logic [6:0] IDX_F2_LO  = 7'h17;
    localparam logic [6:0] IDX_F2_HI  = 7'h18;
    localparam logic [6:0] IDX_GPIO_A = 7'h1C;
    localparam logic [6:0] IDX_GPIO_B = 7'h1D;
    localparam logic [6:0] IDX_GPIO_C = 7'h1E;
    localparam logic [6:0] IDX_PAGE   = 7'h3F;
    localparam logic [6:0] IDX_STATUS = 7'h40;
    localparam logic [6:0] IDX_MARGIN = 7'h4D;

    // Address slicing
    localparam int IDX_LSB = 2;
    localparam int IDX_W   = 7;

    // Field positions in the mode, margin and page bytes
    localparam int TYPE_LSB    = 4;
    localparam int POL_BIT     = 7;
    localparam int HI_MASK_W   = 4;
    localparam int MARGIN_BIT  = 1;
    localparam int PAGE_BIT    = 0;

    // GPIO mode field positions
    localparam int GP2_LSB     = 3;
    localparam int GP3_LO_LSB  = 6;
    localparam int GP3_HI_BIT  = 0;
    localparam int GP5_LSB     = 4;
    localparam int GP6_LO_BIT  = 7;
    localparam int GP6_HI_LSB  = 0;

    // Status register bit positions
    localparam int ST_F1       = 0;
    localparam int ST_F2       = 1;
    localparam int ST_MARGIN   = 2;
    localparam int ST_SEQF     = 3;
    localparam int ST_BANK_LSB = 4;

    // Values after reset
    localparam logic [7:0] RST_CFG       = 8'h00;
    localparam logic       RST_FAULT_LVL = 1'h1;
    localparam logic       RST_PIN_SYNC  = 1'h1;

    // GPIO mode codes
    typedef enum logic [2:0] {
        GM_SPECIAL0 = 3'b000,
        GM_PP_IO    = 3'b001,
        GM_OD_IO    = 3'b010,
        GM_PP_FAULT = 3'b011,
        GM_OD_FAULT = 3'b100,
        GM_IN       = 3'b101,
        GM_WDO      = 3'b110,
        GM_SPECIAL7 = 3'b111
    } fom_gpio_mode_e;

    // DAC register bank selection
    typedef enum logic [1:0] {
        BANK_NOMINAL = 2'b00,
        BANK_RAISE   = 2'b01,
        BANK_LOWER   = 2'b10
    } fom_bank_e;

    // Sequencing fault indicator state
    typedef enum logic {
        SQ_IDLE    = 1'b0,
        SQ_TRIPPED = 1'b1
    } fom_seq_state_e;

endpackage

// ### design/fom_fault_eval.sv
// Purpose: Combines masked channel violations into one fault condition and pin level.
// Assumes: Violation vectors are on the caller's clock, one bit per channel.
// Notes:   Purely combinational; the caller registers the result.
`timescale 1ns/1ns
module fom_fault_eval #(
    parameter int NCH = 12
) (
    // Configuration
    input  wire logic [NCH-1:0] mask,
    input  wire logic [2:0]     type_en,
    input  wire logic           active_high,
    // Violations per channel
    input  wire logic [NCH-1:0] ov,
    input  wire logic [NCH-1:0] uv,
    input  wire logic [NCH-1:0] ew,
    // Result
    output logic                hit,
    output logic                level
);

    // OR of enabled violation types over the selected channels
    assign hit = (type_en[0] & (|(mask & ov)))
               | (type_en[1] & (|(mask & uv)))
               | (type_en[2] & (|(mask & ew)));

    // Polarity applied last
    assign level = active_high ? hit : ~hit;

endmodule

// ### design/fom_top.sv
// Purpose: Drives two supply fault outputs, sequencing fault indicator and DAC bank selection.
// Assumes: Violation vectors and sequencing status arrive on pclk; margin pins are asynchronous.
// Notes:   APB slave with one wait state; extended page holds the DAC switch enables.
// How it works
// - Primary mask selects channels one to twelve
// - Primary OV, UV, EW enables independent
// - Primary polarity bit seven: low or high
// - Secondary mask selects channels one to twelve
// - Secondary OV, UV, EW enables independent
// - Secondary polarity bit seven: low or high
// - Sequencing fault: indicate, enables low, save
// - Raise low, lower high: raise bank, closed
// - Lower low, raise high: lower bank, closed
// - Equal pins: nominal bank, enables set switches
// - Raise or lower pin margin closes switches, enables margin
// - DAC switch enables live in extended page
// - Any selected channel violation asserts output
// - Margin freezes outputs, suppresses logging
//
// Chosen here: the APB slave port.
`timescale 1ns/1ns
module fom_top #(
    parameter int NCH = 12,
    parameter int AW  = 12
) (
    // Clock and reset
    input  wire logic           pclk,
    input  wire logic           presetn,
    // APB slave
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [AW-1:0]  paddr,
    input  wire logic [31:0]    pwdata,
    output logic      [31:0]    prdata,
    output logic                pready,
    output logic                pslverr,
    // Monitor comparator results
    input  wire logic [NCH-1:0] ov_viol,
    input  wire logic [NCH-1:0] uv_viol,
    input  wire logic [NCH-1:0] ew_viol,
    input  wire logic           seq_in_progress,
    // Margin pins
    input  wire logic           margin_raise_input,
    input  wire logic           margin_lower_input,
    input  wire logic           margin_pin_n,
    // Fault pins
    output logic                gpio5_out,
    output logic                gpio5_oe_n,
    output logic                gpio6_out,
    output logic                gpio6_oe_n,
    // Internal levels
    output logic                primary_fault_output,
    output logic                secondary_fault_output,
    output logic                sequencing_fault_indicator,
    output logic                enables_force_low,
    output logic                nv_save_pulse,
    output logic                margin_active,
    output logic [1:0]          trim_dac_bank,
    output logic [NCH-1:0]      trim_dac_output_closed
);

    // Pin drive for a fault-capable GPIO mode: {out, oe_n}
    function automatic logic [1:0] fom_drive(input logic [2:0] mode, input logic lvl);
        case (mode)
            fom_pkg::GM_PP_FAULT: fom_drive = {lvl, 1'h0};
            fom_pkg::GM_OD_FAULT: fom_drive = {1'h0, lvl};
            default:              fom_drive = {1'h0, 1'h1};
        endcase
    endfunction

    // Registers
    logic [7:0]     f1_lo_r;
    logic [7:0]     f1_hi_r;
    logic [7:0]     f2_lo_r;
    logic [7:0]     f2_hi_r;
    logic [7:0]     gpio_a_r;
    logic [7:0]     gpio_b_r;
    logic [7:0]     gpio_c_r;
    logic [NCH-1:0] dac_en_r;
    logic           page_r;
    logic           soft_margin_r;
    logic [31:0]    prdata_r;
    logic           pready_r;
    logic           pslverr_r;
    logic [2:0]     sync1_r;
    logic [2:0]     sync2_r;
    logic           f1_level_r;
    logic           f2_level_r;
    logic           margin_act_r;
    logic [1:0]     bank_r;
    logic [NCH-1:0] dac_sw_r;
    logic           seqf_r;
    logic           force_low_r;
    logic           nv_save_r;
    logic           gp5_out_r;
    logic           gp5_oe_n_r;
    logic           gp6_out_r;
    logic           gp6_oe_n_r;
    fom_pkg::fom_seq_state_e seq_state_r;
    fom_pkg::fom_seq_state_e seq_nxt;

    // Decode and helper nets
    logic [6:0]     idx;
    logic           acc_setup;
    logic           wr_en;
    logic [31:0]    rd_data;
    logic           rd_hit;
    logic [2:0]     gp2_mode;
    logic [2:0]     gp3_mode;
    logic [2:0]     gp5_mode;
    logic [2:0]     gp6_mode;
    logic           raise_lvl;
    logic           lower_lvl;
    logic           sel_raise;
    logic           sel_lower;
    logic           margin_nxt;
    logic           seq_trip;
    logic           seq_clear;
    logic           f1_hit;
    logic           f1_level;
    logic           f2_hit;
    logic           f2_level;
    logic [NCH-1:0] f1_mask;
    logic [NCH-1:0] f2_mask;

    assign idx       = paddr[fom_pkg::IDX_LSB +: fom_pkg::IDX_W];
    assign acc_setup = psel & penable & ~pready_r;
    assign wr_en     = psel & penable & pwrite & pready_r;

    // GPIO mode fields split over the configuration bytes
    assign gp2_mode = gpio_a_r[fom_pkg::GP2_LSB +: 3];
    assign gp3_mode = {gpio_b_r[fom_pkg::GP3_HI_BIT], gpio_a_r[fom_pkg::GP3_LO_LSB +: 2]};
    assign gp5_mode = gpio_b_r[fom_pkg::GP5_LSB +: 3];
    assign gp6_mode = {gpio_c_r[fom_pkg::GP6_HI_LSB +: 2], gpio_b_r[fom_pkg::GP6_LO_BIT]};

    // Channel masks: low byte plus low nibble of the mode byte
    assign f1_mask = {f1_hi_r[fom_pkg::HI_MASK_W-1:0], f1_lo_r};
    assign f2_mask = {f2_hi_r[fom_pkg::HI_MASK_W-1:0], f2_lo_r};

    // Primary fault condition
    fom_fault_eval #(
        .NCH (NCH)
    ) u_f1 (
        .mask        (f1_mask),
        .type_en     (f1_hi_r[fom_pkg::TYPE_LSB +: 3]),
        .active_high (f1_hi_r[fom_pkg::POL_BIT]),
        .ov          (ov_viol),
        .uv          (uv_viol),
        .ew          (ew_viol),
        .hit         (f1_hit),
        .level       (f1_level)
    );

    // Secondary fault condition
    fom_fault_eval #(
        .NCH (NCH)
    ) u_f2 (
        .mask        (f2_mask),
        .type_en     (f2_hi_r[fom_pkg::TYPE_LSB +: 3]),
        .active_high (f2_hi_r[fom_pkg::POL_BIT]),
        .ov          (ov_viol),
        .uv          (uv_viol),
        .ew          (ew_viol),
        .hit         (f2_hit),
        .level       (f2_level)
    );

    // Read mux; extended page maps the DAC switch enables
    always_comb begin
        rd_data = 32'h0;
        rd_hit  = 1'h1;
        case (idx)
            fom_pkg::IDX_F1_LO:  rd_data[7:0] = f1_lo_r;
            fom_pkg::IDX_F1_HI:  rd_data[7:0] = f1_hi_r;
            fom_pkg::IDX_F2_LO:  rd_data[7:0] = f2_lo_r;
            fom_pkg::IDX_F2_HI:  rd_data[7:0] = f2_hi_r;
            fom_pkg::IDX_GPIO_A: rd_data[7:0] = page_r ? dac_en_r[7:0] : gpio_a_r;
            fom_pkg::IDX_GPIO_B: rd_data[7:0] = page_r ? {4'h0, dac_en_r[NCH-1:8]} : gpio_b_r;
            fom_pkg::IDX_GPIO_C: rd_data[7:0] = gpio_c_r;
            fom_pkg::IDX_PAGE:   rd_data[fom_pkg::PAGE_BIT] = page_r;
            fom_pkg::IDX_MARGIN: rd_data[fom_pkg::MARGIN_BIT] = soft_margin_r;
            fom_pkg::IDX_STATUS: begin
                rd_data[fom_pkg::ST_F1]           = f1_level_r;
                rd_data[fom_pkg::ST_F2]           = f2_level_r;
                rd_data[fom_pkg::ST_MARGIN]       = margin_act_r;
                rd_data[fom_pkg::ST_SEQF]         = seqf_r;
                rd_data[fom_pkg::ST_BANK_LSB +: 2] = bank_r;
            end
            default:             rd_hit = 1'h0;
        endcase
    end

    // APB handshake: one wait state, read data and error captured early
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'h0;
            prdata_r  <= 32'h0;
            pslverr_r <= 1'h0;
        end else begin
            pready_r <= acc_setup;
            if (acc_setup) begin
                prdata_r  <= pwrite ? 32'h0 : rd_data;
                pslverr_r <= ~rd_hit;
            end else begin
                pslverr_r <= 1'h0;
            end
        end
    end

    // Configuration register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            f1_lo_r       <= fom_pkg::RST_CFG;
            f1_hi_r       <= fom_pkg::RST_CFG;
            f2_lo_r       <= fom_pkg::RST_CFG;
            f2_hi_r       <= fom_pkg::RST_CFG;
            gpio_a_r      <= fom_pkg::RST_CFG;
            gpio_b_r      <= fom_pkg::RST_CFG;
            gpio_c_r      <= fom_pkg::RST_CFG;
            dac_en_r      <= '0;
            page_r        <= 1'h0;
            soft_margin_r <= 1'h0;
        end else if (wr_en) begin
            case (idx)
                fom_pkg::IDX_F1_LO:  f1_lo_r <= pwdata[7:0];
                fom_pkg::IDX_F1_HI:  f1_hi_r <= pwdata[7:0];
                fom_pkg::IDX_F2_LO:  f2_lo_r <= pwdata[7:0];
                fom_pkg::IDX_F2_HI:  f2_hi_r <= pwdata[7:0];
                fom_pkg::IDX_GPIO_A: begin
                    if (page_r) begin
                        dac_en_r[7:0] <= pwdata[7:0];
                    end else begin
                        gpio_a_r <= pwdata[7:0];
                    end
                end
                fom_pkg::IDX_GPIO_B: begin
                    if (page_r) begin
                        dac_en_r[NCH-1:8] <= pwdata[NCH-9:0];
                    end else begin
                        gpio_b_r <= pwdata[7:0];
                    end
                end
                fom_pkg::IDX_GPIO_C: gpio_c_r <= pwdata[7:0];
                fom_pkg::IDX_PAGE:   page_r <= pwdata[fom_pkg::PAGE_BIT];
                fom_pkg::IDX_MARGIN: soft_margin_r <= pwdata[fom_pkg::MARGIN_BIT];
                default:             page_r <= page_r;
            endcase
        end
    end

    // Two-flop synchronisers for the margin pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= {3{fom_pkg::RST_PIN_SYNC}};
            sync2_r <= {3{fom_pkg::RST_PIN_SYNC}};
        end else begin
            sync1_r <= {margin_pin_n, margin_lower_input, margin_raise_input};
            sync2_r <= sync1_r;
        end
    end

    // Pin levels count only when the GPIO is set up as a margin input
    assign raise_lvl  = (gp2_mode == fom_pkg::GM_SPECIAL7) ? sync2_r[0] : 1'h1;
    assign lower_lvl  = (gp3_mode == fom_pkg::GM_SPECIAL7) ? sync2_r[1] : 1'h1;
    assign sel_raise  = ~raise_lvl & lower_lvl;
    assign sel_lower  = raise_lvl & ~lower_lvl;
    assign margin_nxt = sel_raise | sel_lower | soft_margin_r
                      | ((gp6_mode == fom_pkg::GM_SPECIAL0) & ~sync2_r[2]);

    // Bank select, DAC switches and margin state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bank_r       <= fom_pkg::BANK_NOMINAL;
            dac_sw_r     <= '0;
            margin_act_r <= 1'h0;
        end else begin
            margin_act_r <= margin_nxt;
            if (sel_raise) begin
                bank_r   <= fom_pkg::BANK_RAISE;
                dac_sw_r <= '1;
            end else if (sel_lower) begin
                bank_r   <= fom_pkg::BANK_LOWER;
                dac_sw_r <= '1;
            end else begin
                bank_r   <= fom_pkg::BANK_NOMINAL;
                dac_sw_r <= dac_en_r;
            end
        end
    end

    // Fault levels update only while margining is off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            f1_level_r <= fom_pkg::RST_FAULT_LVL;
            f2_level_r <= fom_pkg::RST_FAULT_LVL;
        end else if (!margin_act_r) begin
            f1_level_r <= f1_level;
            f2_level_r <= f2_level;
        end
    end

    // Sequencing fault: trip during power-up or power-down, cleared by writing one
    assign seq_trip  = (gp6_mode == fom_pkg::GM_SPECIAL7) & seq_in_progress
                     & (|(ov_viol | uv_viol)) & ~margin_act_r;
    assign seq_clear = wr_en & (idx == fom_pkg::IDX_STATUS) & pwdata[fom_pkg::ST_SEQF];

    always_comb begin
        case (seq_state_r)
            fom_pkg::SQ_IDLE:    seq_nxt = seq_trip ? fom_pkg::SQ_TRIPPED : fom_pkg::SQ_IDLE;
            fom_pkg::SQ_TRIPPED: seq_nxt = (seq_clear && !seq_trip) ? fom_pkg::SQ_IDLE : fom_pkg::SQ_TRIPPED;
            default:             seq_nxt = fom_pkg::SQ_IDLE;
        endcase
    end

    // Indicator, enable pull-down and one save request per trip
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_state_r <= fom_pkg::SQ_IDLE;
            seqf_r      <= 1'h0;
            force_low_r <= 1'h0;
            nv_save_r   <= 1'h0;
        end else begin
            seq_state_r <= seq_nxt;
            seqf_r      <= (seq_nxt == fom_pkg::SQ_TRIPPED);
            force_low_r <= (seq_nxt == fom_pkg::SQ_TRIPPED);
            nv_save_r   <= seq_trip & (seq_state_r == fom_pkg::SQ_IDLE);
        end
    end

    // GPIO pin drivers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gp5_out_r  <= 1'h0;
            gp5_oe_n_r <= 1'h1;
            gp6_out_r  <= 1'h0;
            gp6_oe_n_r <= 1'h1;
        end else begin
            {gp5_out_r, gp5_oe_n_r} <= fom_drive(gp5_mode, f1_level_r);
            if (gp6_mode == fom_pkg::GM_SPECIAL7) begin
                gp6_out_r  <= 1'h0;                             // Open-drain, low when tripped
                gp6_oe_n_r <= ~seqf_r;
            end else begin
                {gp6_out_r, gp6_oe_n_r} <= fom_drive(gp6_mode, f2_level_r);
            end
        end
    end

    // Outputs straight from flops
    assign prdata                     = prdata_r;
    assign pready                     = pready_r;
    assign pslverr                    = pslverr_r;
    assign gpio5_out                  = gp5_out_r;
    assign gpio5_oe_n                 = gp5_oe_n_r;
    assign gpio6_out                  = gp6_out_r;
    assign gpio6_oe_n                 = gp6_oe_n_r;
    assign primary_fault_output       = f1_level_r;
    assign secondary_fault_output     = f2_level_r;
    assign sequencing_fault_indicator = seqf_r;
    assign enables_force_low          = force_low_r;
    assign nv_save_pulse              = nv_save_r;
    assign margin_active              = margin_act_r;
    assign trim_dac_bank              = bank_r;
    assign trim_dac_output_closed     = dac_sw_r;

    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_f1_polarity: assert property (!margin_act_r |=> f1_level_r == ($past(f1_hit) ~^ $past(f1_hi_r[7])))
        else $error("primary fault level wrong for polarity");

    chk_f2_polarity: assert property (!margin_act_r |=> f2_level_r == ($past(f2_hit) ~^ $past(f2_hi_r[7])))
        else $error("secondary fault level wrong for polarity");

    chk_any_channel: assert property ((|(f1_mask & ov_viol)) && f1_hi_r[4] && !margin_act_r
        |=> f1_level_r == $past(f1_hi_r[7]))
        else $error("primary fault missed a single channel overvoltage");

    chk_freeze_hold: assert property (margin_act_r |=> $stable(f1_level_r) && $stable(f2_level_r))
        else $error("fault outputs moved while margining");

    chk_no_log_margin: assert property (margin_act_r |=> !nv_save_r)
        else $error("fault save requested while margining");

    chk_raise_bank: assert property (sel_raise |=> bank_r == fom_pkg::BANK_RAISE && &dac_sw_r)
        else $error("raise bank or switches wrong");

    chk_lower_bank: assert property (sel_lower ##1 sel_lower |-> bank_r == fom_pkg::BANK_LOWER && margin_act_r)
        else $error("lower bank or margin state wrong");

    chk_nominal_bank: assert property (!sel_raise && !sel_lower
        |=> bank_r == fom_pkg::BANK_NOMINAL && dac_sw_r == $past(dac_en_r))
        else $error("nominal bank or switch enables wrong");

    chk_seq_trip: assert property (seq_trip && seq_state_r == fom_pkg::SQ_IDLE
        |=> seqf_r && force_low_r && nv_save_r ##1 !nv_save_r)
        else $error("sequencing fault response incomplete");

    chk_apb_wait: assert property (acc_setup |=> pready_r ##1 !pready_r)
        else $error("APB answer not after one wait state");

endmodule

// ### testbench/fom_supply_model.sv
// Purpose: Far-side model of the supplies' comparator results and the board's margin pins.
// Assumes: Levels change by non-blocking assignment just after a rising pclk edge.
// Notes:   Margin pins rest high, their inactive level.
`timescale 1ns/1ns
module fom_supply_model #(
    parameter int NCH = 12
) (
    // Clock
    input  wire logic      pclk,
    // Levels seen by the block
    output logic [NCH-1:0] ov_viol,
    output logic [NCH-1:0] uv_viol,
    output logic [NCH-1:0] ew_viol,
    output logic           seq_in_progress,
    output logic           margin_raise_input,
    output logic           margin_lower_input,
    output logic           margin_pin_n
);
    // Quiet supplies and released pins at time zero
    initial begin
        ov_viol = {NCH{1'b0}};
        uv_viol = {NCH{1'b0}};
        ew_viol = {NCH{1'b0}};
        seq_in_progress = 1'b0;
        margin_raise_input = 1'b1;
        margin_lower_input = 1'b1;
        margin_pin_n = 1'b1;
    end
    // Supply violations and sequencing phase
    task automatic set_supply(input logic [NCH-1:0] ov, uv, ew, input logic seq);
        @(posedge pclk);
        ov_viol <= ov;
        uv_viol <= uv;
        ew_viol <= ew;
        seq_in_progress <= seq;
    endtask
    // Board drives the margin levels once software has set the pin modes
    task automatic set_margin(input logic up, dn);
        @(posedge pclk);
        margin_raise_input <= up;
        margin_lower_input <= dn;
    endtask
endmodule

// ### testbench/fault_output_and_margin_select_test.sv
// Purpose: Self-checking bench for fault outputs, sequencing fault and margin bank select.
// Assumes: APB slave answers after one wait state; fault outputs settle one edge after inputs.
// Notes:   Margin pins need three edges to reach the outputs, so four are allowed.
`timescale 1ns/1ns
module fault_output_and_margin_select_test;
    // Clock, reset and APB
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [11:0] ov, uv, ew, sw;
    logic        seq, up, dn, mpin, pfo, sfo, ind, frc, sav, mact, g6oe, err, g5o, g5oe, g6o;
    logic [1:0]  bank;
    int          num_errors = 0;
    int          checked = 0;
    fom_top fom_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ov_viol(ov), .uv_viol(uv), .ew_viol(ew), .seq_in_progress(seq), .margin_raise_input(up),
        .margin_lower_input(dn), .margin_pin_n(mpin), .gpio5_out(g5o), .gpio5_oe_n(g5oe), .gpio6_out(g6o),
        .gpio6_oe_n(g6oe), .primary_fault_output(pfo), .secondary_fault_output(sfo),
        .sequencing_fault_indicator(ind), .enables_force_low(frc), .nv_save_pulse(sav),
        .margin_active(mact), .trim_dac_bank(bank), .trim_dac_output_closed(sw));
    fom_supply_model fom_supply_model_inst (.pclk(pclk), .ov_viol(ov), .uv_viol(uv), .ew_viol(ew),
        .seq_in_progress(seq), .margin_raise_input(up), .margin_lower_input(dn), .margin_pin_n(mpin));
    // Verdict and end of run
    task automatic complete_run();
        if (num_errors == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Value comparison
    task automatic chk(input string what, input logic [31:0] exp, got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [6:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {3'h0, idx, 2'h0};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("pready", 1'h1, {31'h0, pready});
    endtask
    // Drive violations, let the registered outputs settle, compare both fault pins
    task automatic fault(input logic [11:0] o, u, e, input logic [1:0] exp);
        fom_supply_model_inst.set_supply(o, u, e, 1'b0);
        repeat (2) @(posedge pclk);
        #1 chk("fault pins", exp, {pfo, sfo});
    endtask
    // Drive margin pins and compare bank, switches and margin state
    task automatic margin(input logic u, d, input logic [14:0] exp);
        fom_supply_model_inst.set_margin(u, d);
        repeat (4) @(posedge pclk);
        #1 chk("margin", exp, {mact, bank, sw});
    endtask
    // Clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // Watchdog
    initial begin
        repeat (5000) @(posedge pclk);
        num_errors++;
        complete_run();
    end
    // Test sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1 chk("reset pins", 2'h3, {pfo, sfo});
        apb(1'b1, fom_pkg::IDX_F1_LO, 32'h01);
        apb(1'b1, fom_pkg::IDX_F1_HI, 32'h11);
        apb(1'b1, fom_pkg::IDX_F2_HI, 32'hC8);
        apb(1'b0, fom_pkg::IDX_F2_HI, 32'h0);
        chk("mode byte", 32'hC8, rd);
        fault(12'h001, 12'h000, 12'h000, 2'h0);
        fault(12'h100, 12'h000, 12'h000, 2'h0);
        fault(12'h000, 12'h001, 12'h000, 2'h2);
        fault(12'h002, 12'h000, 12'h800, 2'h3);
        fault(12'h800, 12'h000, 12'h000, 2'h2);
        fault(12'h000, 12'h000, 12'h000, 2'h2);
        apb(1'b1, fom_pkg::IDX_F1_HI, 32'hB1);
        fault(12'h000, 12'h100, 12'h000, 2'h2);
        apb(1'b1, 7'h05, 32'hFF);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, fom_pkg::IDX_GPIO_A, 32'hF8);
        apb(1'b1, fom_pkg::IDX_GPIO_B, 32'h31);
        apb(1'b1, fom_pkg::IDX_PAGE, 32'h01);
        apb(1'b1, fom_pkg::IDX_GPIO_A, 32'h05);
        apb(1'b1, fom_pkg::IDX_GPIO_B, 32'h02);
        apb(1'b1, fom_pkg::IDX_PAGE, 32'h00);
        margin(1'b0, 1'b1, 15'h5FFF);
        fault(12'h000, 12'h000, 12'h000, 2'h2);
        chk("gpio5 drive", 32'h2, {30'h0, g5o, g5oe});
        margin(1'b1, 1'b0, 15'h6FFF);
        margin(1'b0, 1'b0, 15'h0205);
        margin(1'b1, 1'b1, 15'h0205);
        apb(1'b1, fom_pkg::IDX_MARGIN, 32'h02);
        apb(1'b0, fom_pkg::IDX_STATUS, 32'h0);
        chk("status", 32'h04, rd);
        apb(1'b1, fom_pkg::IDX_MARGIN, 32'h00);
        apb(1'b1, fom_pkg::IDX_GPIO_B, 32'hB1);
        apb(1'b1, fom_pkg::IDX_GPIO_C, 32'h03);
        fom_supply_model_inst.set_supply(12'h000, 12'h004, 12'h000, 1'b1);
        @(posedge pclk);
        #1 chk("seq trip", 3'h7, {ind, frc, sav});
        @(posedge pclk);
        #1 chk("seq hold", 5'h18, {ind, frc, sav, g6o, g6oe});
        fom_supply_model_inst.set_supply(12'h000, 12'h000, 12'h000, 1'b0);
        apb(1'b1, fom_pkg::IDX_STATUS, 32'h08);
        @(posedge pclk);
        #1 chk("seq clear", 2'h0, {ind, frc});
        complete_run();
    end
endmodule
